// [eau_effective_address_unit.sv]
`timescale 1ns/10ps
// Overview of operation
// - specifier splits into mode and register subfields
// - register subfield is register number or submode
// - extra address words fetched from instruction stream
// - opcode, extension, immediate, pc-relative reads: program
// - operand writes always go to data space
// - implicit registers read without any specifier
// - data register direct uses numbered data register
// - address register direct uses numbered address register
// - indirect uses address register, register unchanged
// - postincrement uses address then adds 1/2/4
// - byte postincrement of stack pointer adds two
// - predecrement subtracts 1/2/4 then uses address
// - byte predecrement of stack pointer subtracts two
// - displacement mode adds sign-extended 16-bit word
// - every displacement sign-extended to 32 bits
// - brief index: base plus d8 plus scaled index
// - extension bit 15 picks data or address index
// - extension bits 14:12 give index register number
// - bit 11: sign-extended word or long index
// - bits 10:9 scale index by 1,2,4,8
// - brief index off an address register is data space except jumps
// - base-displacement index adds optional 16/32-bit displacement
// - address register seven maps by privilege level
// - all-ones mode decodes register field as submode
module eau_effective_address_unit (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic start,
	input wire eau_pkg::eau_req_t req,
	input wire logic supervisor,
	input wire logic [31:0] pc_in,
	input wire logic [15:0] status_word,
	input wire logic ext_valid,
	input wire logic [15:0] ext_word,
	input wire logic load_en,
	input wire logic [4:0] load_idx,
	input wire logic [31:0] load_data,
	input wire logic impl_req,
	input wire eau_pkg::eau_impl_t impl_sel,
	output logic idle,
	output logic ext_req,
	output logic done,
	output eau_pkg::eau_result_t result,
	output logic impl_valid,
	output logic [31:0] impl_data
);
	typedef enum logic [2:0] {S_IDLE, S_BASE, S_EXT, S_IDX, S_BD} eau_state_t;

	eau_state_t state_reg, state_next;
	eau_pkg::eau_req_t req_reg;
	eau_pkg::eau_result_t res_next;
	logic sup_reg;
	logic [31:0] pc_reg, base_reg, base_next, index_reg, index_next, bd_reg, bd_next;
	logic [15:0] ext_reg, ext_next;
	logic [1:0] bd_cnt_reg, bd_cnt_next;
	logic [4:0] base_idx_reg;
	logic done_next, wb_en;
	logic [31:0] wb_data;
	logic impl_pend_reg;
	eau_pkg::eau_impl_t impl_sel_reg;
	logic [31:0] impl_next;

	function automatic logic [4:0] phys(input logic is_addr, input logic [2:0] num,
		input logic sup);
		if (!is_addr) begin
			return {2'b00, num};
		end else if (num == eau_pkg::SP_NUM) begin
			return sup ? eau_pkg::IDX_SSP : eau_pkg::IDX_USP;
		end
		return eau_pkg::IDX_AREG0 + {2'b00, num};
	endfunction

	// mode/register split of the specifier
	wire [2:0] in_mode = req.ea[eau_pkg::EA_MODE_HI:eau_pkg::EA_MODE_LO];
	wire [2:0] in_regf = req.ea[eau_pkg::EA_REG_HI:eau_pkg::EA_REG_LO];
	wire [2:0] mode = req_reg.ea[eau_pkg::EA_MODE_HI:eau_pkg::EA_MODE_LO];
	wire [2:0] regf = req_reg.ea[eau_pkg::EA_REG_HI:eau_pkg::EA_REG_LO];
	wire is_spec = (mode == eau_pkg::MODE_SPEC);
	wire [2:0] submode = regf;
	wire taken = (state_reg == S_IDLE) && start;
	wire ext_take = ext_req && ext_valid;

	wire [4:0] in_phys = phys(in_mode != eau_pkg::MODE_DREG, in_regf, supervisor);
	wire [4:0] idx_phys = phys(ext_word[eau_pkg::EXT_DA],
		ext_word[eau_pkg::EXT_IDX_HI:eau_pkg::EXT_IDX_LO], sup_reg);
	wire [4:0] impl_phys = (impl_sel == eau_pkg::EAU_IMPL_USP) ? eau_pkg::IDX_USP :
		(impl_sel == eau_pkg::EAU_IMPL_SSP) ? eau_pkg::IDX_SSP :
		phys(1'b1, eau_pkg::SP_NUM, supervisor);
	wire [4:0] rd_a_addr = (state_reg == S_IDLE) ? in_phys : base_idx_reg;
	wire [4:0] rd_b_addr = (state_reg == S_EXT) ? idx_phys : impl_phys;
	wire [31:0] rd_a_data, rd_b_data;

	// the stack pointer never goes odd, so byte steps on it are doubled
	wire sp_byte = (req_reg.size == eau_pkg::SIZE_BYTE) && (regf == eau_pkg::SP_NUM);
	wire [31:0] step = sp_byte ? eau_pkg::STEP_TWO :
		(req_reg.size == eau_pkg::SIZE_BYTE) ? eau_pkg::STEP_ONE :
		(req_reg.size == eau_pkg::SIZE_WORD) ? eau_pkg::STEP_TWO : eau_pkg::STEP_FOUR;

	// index operand from the freshly read index register
	wire [31:0] idx_raw = ext_reg[eau_pkg::EXT_SIZE] ? rd_b_data :
		eau_pkg::sext16(rd_b_data[15:0]);
	wire [31:0] idx_scaled = idx_raw << ext_reg[eau_pkg::EXT_SCL_HI:eau_pkg::EXT_SCL_LO];
	wire is_full = ext_reg[eau_pkg::EXT_FULL];
	wire [1:0] bd_size = ext_reg[eau_pkg::EXT_BDS_HI:eau_pkg::EXT_BDS_LO];
	wire [31:0] d8 = eau_pkg::sext8(ext_reg[eau_pkg::EXT_D8_HI:0]);
	wire [31:0] d16 = eau_pkg::sext16(ext_word);
	wire [31:0] bd_full = (bd_size == eau_pkg::BDS_WORD) ? eau_pkg::sext16(ext_word) :
		{bd_reg[15:0], ext_word};

	// program space for pc-relative and immediate reads, jumps through an index
	wire pc_space = is_spec && (submode == eau_pkg::SUB_PCD16 ||
		submode == eau_pkg::SUB_PCIDX || submode == eau_pkg::SUB_IMM);
	wire jump_space = (mode == eau_pkg::MODE_INDEX) && req_reg.is_jump;
	wire prog_ref = !req_reg.is_write && (pc_space || jump_space);
	wire eau_pkg::eau_space_t space = prog_ref ? eau_pkg::EAU_SPACE_PROG :
		eau_pkg::EAU_SPACE_DATA;

	// one write port: pointer update has priority over an outside load
	wire wr_en = wb_en || load_en;
	wire [4:0] wr_addr = wb_en ? base_idx_reg : load_idx;
	wire [31:0] wr_data = wb_en ? wb_data : load_data;

	eau_regfile u_regfile (
		.clk(clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.rd_a_addr(rd_a_addr),
		.rd_b_addr(rd_b_addr),
		.rd_a_data(rd_a_data),
		.rd_b_data(rd_b_data),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	always_comb begin
		state_next = state_reg;
		res_next = result;
		done_next = 1'b0;
		base_next = base_reg;
		index_next = index_reg;
		ext_next = ext_reg;
		bd_next = bd_reg;
		bd_cnt_next = bd_cnt_reg;
		wb_en = 1'b0;
		wb_data = rd_a_data;
		case (state_reg)
			S_IDLE: begin
				if (start) begin
					state_next = S_BASE;
				end
			end
			S_BASE: begin
				state_next = S_IDLE;
				done_next = 1'b1;
				res_next = eau_pkg::RESULT_RST;
				res_next.space = space;
				res_next.reg_idx = base_idx_reg;
				res_next.kind = eau_pkg::EAU_KIND_MEM;
				base_next = rd_a_data;
				case (mode)
					eau_pkg::MODE_DREG: begin
						res_next.kind = eau_pkg::EAU_KIND_DREG;
						res_next.operand = rd_a_data;
					end
					eau_pkg::MODE_AREG: begin
						res_next.kind = eau_pkg::EAU_KIND_AREG;
						res_next.operand = rd_a_data;
					end
					eau_pkg::MODE_IND: begin
						res_next.addr = rd_a_data;
					end
					eau_pkg::MODE_POST: begin
						res_next.addr = rd_a_data;
						wb_en = 1'b1;
						wb_data = rd_a_data + step;
					end
					eau_pkg::MODE_PRE: begin
						res_next.addr = rd_a_data - step;
						wb_en = 1'b1;
						wb_data = rd_a_data - step;
					end
					eau_pkg::MODE_DISP, eau_pkg::MODE_INDEX: begin
						state_next = S_EXT;
						done_next = 1'b0;
					end
					default: begin
						base_next = pc_reg;
						res_next.reg_idx = 5'h00;
						if (submode == eau_pkg::SUB_PCD16 || submode == eau_pkg::SUB_PCIDX) begin
							state_next = S_EXT;
							done_next = 1'b0;
						end else if (submode == eau_pkg::SUB_IMM) begin
							res_next.kind = eau_pkg::EAU_KIND_IMM;
							res_next.addr = pc_reg;
						end else begin
							res_next.illegal = 1'b1;
						end
						// pc-relative and immediate operands cannot be written
						// finish at once so no extension word is ever awaited
						if (req_reg.is_write) begin
							res_next.illegal = 1'b1;
							state_next = S_IDLE;
							done_next = 1'b1;
						end
					end
				endcase
			end
			S_EXT: begin
				if (ext_take) begin
					ext_next = ext_word;
					if (mode == eau_pkg::MODE_DISP || (is_spec && submode == eau_pkg::SUB_PCD16)) begin
						state_next = S_IDLE;
						done_next = 1'b1;
						res_next.addr = base_reg + d16;
					end else begin
						state_next = S_IDX;
					end
				end
			end
			S_IDX: begin
				index_next = idx_scaled;
				if (is_full && (bd_size == eau_pkg::BDS_WORD || bd_size == eau_pkg::BDS_LONG)) begin
					state_next = S_BD;
					bd_cnt_next = (bd_size == eau_pkg::BDS_WORD) ? eau_pkg::BD_CNT_WORD :
						eau_pkg::BD_CNT_LONG;
				end else begin
					state_next = S_IDLE;
					done_next = 1'b1;
					res_next.addr = base_reg + idx_scaled + (is_full ? eau_pkg::WORD_RST : d8);
				end
			end
			S_BD: begin
				if (ext_take) begin
					bd_next = {bd_reg[15:0], ext_word};
					bd_cnt_next = bd_cnt_reg - 2'h1;
					if (bd_cnt_reg == eau_pkg::BD_CNT_WORD) begin
						state_next = S_IDLE;
						done_next = 1'b1;
						res_next.addr = base_reg + index_reg + bd_full;
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// implicit reads: pc and status word come from outside, stack pointers from the file
	always_comb begin
		case (impl_sel_reg)
			eau_pkg::EAU_IMPL_PC: impl_next = pc_in;
			eau_pkg::EAU_IMPL_SR: impl_next = {16'h0000, status_word};
			default: impl_next = rd_b_data;
		endcase
	end

	wire impl_take = impl_req && (state_reg == S_IDLE);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_IDLE;
			req_reg <= eau_pkg::REQ_RST;
			sup_reg <= 1'b0;
			pc_reg <= eau_pkg::WORD_RST;
			base_idx_reg <= 5'h00;
		end else if (clk_en && taken) begin
			state_reg <= state_next;
			req_reg <= req;
			sup_reg <= supervisor;
			pc_reg <= pc_in;
			base_idx_reg <= in_phys;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			base_reg <= eau_pkg::WORD_RST;
			index_reg <= eau_pkg::WORD_RST;
			bd_reg <= eau_pkg::WORD_RST;
			ext_reg <= eau_pkg::EXT_RST;
			bd_cnt_reg <= 2'h0;
		end else if (clk_en) begin
			base_reg <= base_next;
			index_reg <= index_next;
			bd_reg <= bd_next;
			ext_reg <= ext_next;
			bd_cnt_reg <= bd_cnt_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle <= 1'b1;
			ext_req <= 1'b0;
			done <= 1'b0;
			result <= eau_pkg::RESULT_RST;
		end else if (clk_en) begin
			idle <= (state_next == S_IDLE);
			ext_req <= (state_next == S_EXT) || (state_next == S_BD);
			done <= done_next;
			result <= res_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			impl_pend_reg <= 1'b0;
			impl_sel_reg <= eau_pkg::EAU_IMPL_PC;
			impl_valid <= 1'b0;
			impl_data <= eau_pkg::WORD_RST;
		end else if (clk_en) begin
			impl_pend_reg <= impl_take;
			impl_sel_reg <= impl_take ? impl_sel : impl_sel_reg;
			impl_valid <= impl_pend_reg;
			impl_data <= impl_pend_reg ? impl_next : impl_data;
		end
	end

	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (!rst_b);

	sequence s_start_mode(logic [2:0] m);
		taken && (in_mode == m);
	endsequence

	property p_dreg;
		s_start_mode(eau_pkg::MODE_DREG) |-> ##2 done && result.kind == eau_pkg::EAU_KIND_DREG;
	endproperty
	a_dreg: assert property (p_dreg) else $error("data direct gave no data result");

	property p_a7_super;
		s_start_mode(eau_pkg::MODE_AREG) and (in_regf == eau_pkg::SP_NUM && supervisor)
			|-> ##2 done && result.reg_idx == eau_pkg::IDX_SSP;
	endproperty
	a_a7_super: assert property (p_a7_super) else $error("register seven not mapped");

	property p_ind_same;
		s_start_mode(eau_pkg::MODE_IND) |-> ##1 !wb_en ##1 done && result.addr == $past(rd_a_data);
	endproperty
	a_ind_same: assert property (p_ind_same) else $error("indirect address wrong");

	property p_post_step;
		(state_reg == S_BASE && mode == eau_pkg::MODE_POST && !sp_byte &&
			req_reg.size == eau_pkg::SIZE_LONG) |-> wr_data == rd_a_data + 32'h4
			##1 done && result.addr == $past(rd_a_data);
	endproperty
	a_post_step: assert property (p_post_step) else $error("postincrement wrong");

	property p_pre_sp_byte;
		(state_reg == S_BASE && mode == eau_pkg::MODE_PRE && sp_byte)
			|=> done && result.addr == $past(rd_a_data) - 32'h2;
	endproperty
	a_pre_sp_byte: assert property (p_pre_sp_byte) else $error("stack byte step wrong");

	property p_disp;
		(state_reg == S_EXT && ext_valid && mode == eau_pkg::MODE_DISP)
			|=> done && result.addr == base_reg + {{16{$past(ext_word[15])}}, $past(ext_word)};
	endproperty
	a_disp: assert property (p_disp) else $error("displacement address wrong");

	property p_ext_wait;
		(state_reg == S_EXT && !ext_valid) |-> ext_req ##1 (state_reg == S_EXT && !done);
	endproperty
	a_ext_wait: assert property (p_ext_wait) else $error("left without extension word");

	property p_write_data;
		done && req_reg.is_write |-> result.space == eau_pkg::EAU_SPACE_DATA;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write not in data space");

	property p_index_space;
		done && mode == eau_pkg::MODE_INDEX && !req_reg.is_write
			|-> (result.space == eau_pkg::EAU_SPACE_PROG) == req_reg.is_jump;
	endproperty
	a_index_space: assert property (p_index_space) else $error("index space wrong");

	property p_impl;
		impl_take |-> ##2 impl_valid;
	endproperty
	a_impl: assert property (p_impl) else $error("implicit read not answered");
endmodule // eau_effective_address_unit

// [eau_fetch_model.sv]
`timescale 1ns/10ps
// extension-word fetch side: answers after lat cycles and withdraws a word once taken
module eau_fetch_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic new_op,
	input wire logic ext_req,
	input wire logic [15:0] w0,
	input wire logic [15:0] w1,
	input wire logic [15:0] w2,
	input wire logic [1:0] nwords,
	input wire logic [1:0] lat,
	output logic ext_valid,
	output logic [15:0] ext_word
);
	logic [1:0] idx_reg;
	logic [1:0] wait_reg;
	logic [15:0] pick;
	// words follow the operation word in order, high half of a long displacement first
	assign pick = (idx_reg == 2'h0) ? w0 : ((idx_reg == 2'h1) ? w1 : w2);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idx_reg <= 2'h0;
			wait_reg <= 2'h0;
			ext_valid <= 1'b0;
			ext_word <= 16'hA5A5;
		end else if (new_op) begin
			// word order restarts per operation only: ext_req may drop between words
			idx_reg <= 2'h0;
			wait_reg <= lat;
			ext_valid <= 1'b0;
			ext_word <= ~ext_word;
		end else if (ext_req && ext_valid) begin
			idx_reg <= idx_reg + 2'h1;
			wait_reg <= lat;
			ext_valid <= 1'b0;
			ext_word <= ~ext_word;
		end else if (ext_req && !ext_valid && idx_reg < nwords && wait_reg == 2'h0) begin
			ext_valid <= 1'b1;
			ext_word <= pick;
		end else if (!ext_valid) begin
			// a toggling bus so a stale word can never pass for a fresh one
			ext_word <= ~ext_word;
			if (!ext_req) begin
				wait_reg <= lat;
			end else if (wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
			end
		end
	end
endmodule // eau_fetch_model

// [eau_pkg.sv]
package eau_pkg;
	// effective-address specifier layout
	localparam int EA_MODE_HI = 5;
	localparam int EA_MODE_LO = 3;
	localparam int EA_REG_HI = 2;
	localparam int EA_REG_LO = 0;
	// mode subfield codes
	localparam logic [2:0] MODE_DREG = 3'h0;
	localparam logic [2:0] MODE_AREG = 3'h1;
	localparam logic [2:0] MODE_IND = 3'h2;
	localparam logic [2:0] MODE_POST = 3'h3;
	localparam logic [2:0] MODE_PRE = 3'h4;
	localparam logic [2:0] MODE_DISP = 3'h5;
	localparam logic [2:0] MODE_INDEX = 3'h6;
	localparam logic [2:0] MODE_SPEC = 3'h7;
	// submodes under MODE_SPEC
	localparam logic [2:0] SUB_PCD16 = 3'h2;
	localparam logic [2:0] SUB_PCIDX = 3'h3;
	localparam logic [2:0] SUB_IMM = 3'h4;
	// operand size codes and address steps
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [31:0] STEP_ONE = 32'h0000_0001;
	localparam logic [31:0] STEP_TWO = 32'h0000_0002;
	localparam logic [31:0] STEP_FOUR = 32'h0000_0004;
	localparam logic [2:0] SP_NUM = 3'h7;
	// physical register file slots
	localparam int RF_DEPTH = 17;
	localparam logic [4:0] IDX_AREG0 = 5'h08;
	localparam logic [4:0] IDX_USP = 5'h0F;
	localparam logic [4:0] IDX_SSP = 5'h10;
	// extension word fields
	localparam int EXT_DA = 15;
	localparam int EXT_IDX_HI = 14;
	localparam int EXT_IDX_LO = 12;
	localparam int EXT_SIZE = 11;
	localparam int EXT_SCL_HI = 10;
	localparam int EXT_SCL_LO = 9;
	localparam int EXT_FULL = 8;
	localparam int EXT_D8_HI = 7;
	localparam int EXT_BDS_HI = 5;
	localparam int EXT_BDS_LO = 4;
	localparam logic [1:0] BDS_WORD = 2'h2;
	localparam logic [1:0] BDS_LONG = 2'h3;
	localparam logic [1:0] BD_CNT_WORD = 2'h1;
	localparam logic [1:0] BD_CNT_LONG = 2'h2;
	// reset values
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [15:0] EXT_RST = 16'h0000;

	typedef enum logic [1:0] {EAU_KIND_DREG, EAU_KIND_AREG, EAU_KIND_MEM, EAU_KIND_IMM} eau_kind_t;
	typedef enum logic {EAU_SPACE_DATA, EAU_SPACE_PROG} eau_space_t;
	typedef enum logic [2:0] {EAU_IMPL_PC, EAU_IMPL_SP, EAU_IMPL_USP, EAU_IMPL_SSP,
		EAU_IMPL_SR} eau_impl_t;

	typedef struct packed {
		logic [5:0] ea;
		logic [1:0] size;
		logic is_write;
		logic is_jump;
	} eau_req_t;

	typedef struct packed {
		eau_kind_t kind;
		eau_space_t space;
		logic illegal;
		logic [4:0] reg_idx;
		logic [31:0] addr;
		logic [31:0] operand;
	} eau_result_t;

	localparam eau_result_t RESULT_RST = '0;
	localparam eau_req_t REQ_RST = '0;

	function automatic logic [31:0] sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] sext8(input logic [7:0] v);
		return {{24{v[7]}}, v};
	endfunction
endpackage

// [eau_regfile.sv]
`timescale 1ns/10ps
// data registers, address registers and both stack pointers; reads are registered
module eau_regfile (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [4:0] rd_a_addr,
	input wire logic [4:0] rd_b_addr,
	output logic [31:0] rd_a_data,
	output logic [31:0] rd_b_data,
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [31:0] wr_data
);
	logic [31:0] mem [eau_pkg::RF_DEPTH];

	always_ff @(posedge clk) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read of a slot written in the same cycle returns the old value
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_a_data <= eau_pkg::WORD_RST;
			rd_b_data <= eau_pkg::WORD_RST;
		end else if (clk_en) begin
			rd_a_data <= mem[rd_a_addr];
			rd_b_data <= mem[rd_b_addr];
		end
	end
endmodule // eau_regfile

// [tb_top.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic clk, rst_b, clk_en, start, supervisor, load_en, impl_req;
	eau_pkg::eau_req_t req;
	logic [31:0] pc_in, load_data, impl_data;
	logic [15:0] status_word, ext_word, w0, w1, w2;
	logic ext_valid, idle, ext_req, done, impl_valid;
	logic [4:0] load_idx;
	eau_pkg::eau_impl_t impl_sel;
	eau_pkg::eau_result_t result;
	logic [1:0] nwords, lat;
	logic [31:0] rf [0:16];
	int errors, checks, cyc;

	eau_effective_address_unit u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .start(start),
		.req(req), .supervisor(supervisor), .pc_in(pc_in), .status_word(status_word),
		.ext_valid(ext_valid), .ext_word(ext_word), .load_en(load_en), .load_idx(load_idx),
		.load_data(load_data), .impl_req(impl_req), .impl_sel(impl_sel), .idle(idle),
		.ext_req(ext_req), .done(done), .result(result), .impl_valid(impl_valid),
		.impl_data(impl_data));
	eau_fetch_model u_fetch (.clk(clk), .rst_b(rst_b), .new_op(start), .ext_req(ext_req),
		.w0(w0), .w1(w1),
		.w2(w2), .nwords(nwords), .lat(lat), .ext_valid(ext_valid), .ext_word(ext_word));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	function automatic logic [4:0] aslot(input logic [2:0] n, input logic s);
		if (n == eau_pkg::SP_NUM)
			return s ? eau_pkg::IDX_SSP : eau_pkg::IDX_USP;
		return eau_pkg::IDX_AREG0 + {2'h0, n};
	endfunction
	function automatic logic [31:0] sx16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction
	function automatic logic [31:0] index_op(input logic [15:0] e, input logic s);
		logic [31:0] v;
		v = e[15] ? rf[aslot(e[14:12], s)] : rf[{2'h0, e[14:12]}];
		if (!e[11])
			v = sx16(v[15:0]);
		return v << e[10:9];
	endfunction
	function automatic logic [31:0] step(input logic [1:0] sz, input logic [2:0] n);
		if (sz == eau_pkg::SIZE_BYTE)
			return (n == eau_pkg::SP_NUM) ? 32'h0000_0002 : 32'h0000_0001;
		return (sz == eau_pkg::SIZE_WORD) ? 32'h0000_0002 : 32'h0000_0004;
	endfunction

	task automatic print_verdict();
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic load_reg(input logic [4:0] i, input logic [31:0] v);
		@(negedge clk);
		load_en = 1'b1;
		load_idx = i;
		load_data = v;
		rf[i] = v;
		@(negedge clk);
		load_en = 1'b0;
	endtask

	// entered at a falling edge; returns at the falling edge of the done cycle
	task automatic run_op(input logic [5:0] ea, input logic [1:0] sz, input logic w,
		input logic j, input logic s, input logic [15:0] e0, input logic [15:0] e1,
		input logic [15:0] e2);
		logic [2:0] md, rn;
		logic [4:0] sl;
		logic [31:0] a, b, pc;
		eau_pkg::eau_kind_t k;
		eau_pkg::eau_space_t sp;
		logic ill, xi;
		logic [1:0] nw;
		int t;
		md = ea[5:3];
		rn = ea[2:0];
		pc = $urandom();
		sl = (md == eau_pkg::MODE_DREG) ? {2'h0, rn} : aslot(rn, s);
		b = (md == eau_pkg::MODE_SPEC) ? pc : rf[sl];
		a = b;
		k = eau_pkg::EAU_KIND_MEM;
		sp = eau_pkg::EAU_SPACE_DATA;
		ill = 1'b0;
		nw = 2'h0;
		xi = md == eau_pkg::MODE_INDEX || (md == eau_pkg::MODE_SPEC && rn == eau_pkg::SUB_PCIDX);
		if (md == eau_pkg::MODE_DREG)
			k = eau_pkg::EAU_KIND_DREG;
		if (md == eau_pkg::MODE_AREG)
			k = eau_pkg::EAU_KIND_AREG;
		if (md == eau_pkg::MODE_PRE)
			a = b - step(sz, rn);
		if (md == eau_pkg::MODE_DISP || (md == eau_pkg::MODE_SPEC && rn == eau_pkg::SUB_PCD16)) begin
			a = b + sx16(e0);
			nw = 2'h1;
		end
		if (xi) begin
			nw = 2'h1;
			a = b + index_op(e0, s) + {{24{e0[7]}}, e0[7:0]};
			if (e0[8]) begin
				a = b + index_op(e0, s);
				if (e0[5:4] == eau_pkg::BDS_WORD) begin
					a = a + sx16(e1);
					nw = 2'h2;
				end
				if (e0[5:4] == eau_pkg::BDS_LONG) begin
					a = a + {e1, e2};
					nw = 2'h3;
				end
			end
			if (j)
				sp = eau_pkg::EAU_SPACE_PROG;
		end
		if (md == eau_pkg::MODE_SPEC) begin
			sp = eau_pkg::EAU_SPACE_PROG;
			ill = !(rn inside {eau_pkg::SUB_PCD16, eau_pkg::SUB_PCIDX, eau_pkg::SUB_IMM}) || w;
			if (rn == eau_pkg::SUB_IMM)
				k = eau_pkg::EAU_KIND_IMM;
			if (ill)
				nw = 2'h0;
		end
		if (w)
			sp = eau_pkg::EAU_SPACE_DATA;
		t = 0;
		while (idle !== 1'b1 && t < 50) begin
			@(negedge clk);
			t++;
		end
		w0 = e0;
		w1 = e1;
		w2 = e2;
		nwords = nw;
		lat = 2'($urandom_range(3));
		pc_in = pc;
		supervisor = s;
		req = '{ea: ea, size: sz, is_write: w, is_jump: j};
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		t = 0;
		while (done !== 1'b1 && t < 40) begin
			@(negedge clk);
			t++;
		end
		`CHK("done", 1'b1, done)
		`CHK("illegal", ill, result.illegal)
		if (!ill) begin
			`CHK("kind", k, result.kind)
			`CHK("space", sp, result.space)
			if (md == eau_pkg::MODE_DREG || md == eau_pkg::MODE_AREG) begin
				`CHK("reg_idx", sl, result.reg_idx)
				`CHK("operand", rf[sl], result.operand)
			end else begin
				`CHK("addr", a, result.addr)
			end
		end
		if (md == eau_pkg::MODE_POST)
			rf[sl] = b + step(sz, rn);
		if (md == eau_pkg::MODE_PRE)
			rf[sl] = a;
	endtask

	task automatic impl_chk(input int i, input logic s);
		logic [31:0] x;
		int t;
		status_word = 16'($urandom());
		x = {16'h0000, status_word};
		if (i == 0)
			x = pc_in;
		if (i == 1)
			x = rf[s ? eau_pkg::IDX_SSP : eau_pkg::IDX_USP];
		if (i == 2)
			x = rf[eau_pkg::IDX_USP];
		if (i == 3)
			x = rf[eau_pkg::IDX_SSP];
		supervisor = s;
		impl_sel = eau_pkg::eau_impl_t'(3'(i));
		impl_req = 1'b1;
		@(negedge clk);
		impl_req = 1'b0;
		t = 0;
		while (impl_valid !== 1'b1 && t < 6) begin
			@(negedge clk);
			t++;
		end
		`CHK("impl_valid", 1'b1, impl_valid)
		`CHK("impl_data", x, impl_data)
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		logic [5:0] ea;
		clk_en = 1'b1;
		start = 1'b0;
		req = eau_pkg::REQ_RST;
		supervisor = 1'b0;
		pc_in = 32'h0000_0000;
		status_word = 16'h0000;
		load_en = 1'b0;
		load_idx = 5'h00;
		load_data = 32'h0000_0000;
		impl_req = 1'b0;
		impl_sel = eau_pkg::EAU_IMPL_PC;
		{w0, w1, w2} = 48'h0;
		nwords = 2'h0;
		lat = 2'h0;
		rst_b = 1'b0;
		void'($urandom(32'hFFFA));
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		`CHK("idle", 1'b1, idle)
		for (int i = 0; i < 17; i++)
			load_reg(5'(i), $urandom());
		// carry out of bit 31 is dropped
		load_reg(eau_pkg::IDX_AREG0 + 5'h01, 32'hFFFF_FFFE);
		run_op({eau_pkg::MODE_DISP, 3'h1}, 2'h1, 1'b0, 1'b0, 1'b0, 16'h0004, 16'h0, 16'h0);
		for (int i = 0; i < 6; i++) begin
			run_op({eau_pkg::MODE_POST, 3'h7}, 2'(i % 3), 1'b0, 1'b0, i[0], 16'h0, 16'h0, 16'h0);
			run_op({eau_pkg::MODE_PRE, 3'h7}, 2'(i % 3), 1'b1, 1'b0, i[0], 16'h0, 16'h0, 16'h0);
		end
		for (int i = 0; i < 8; i++)
			run_op({eau_pkg::MODE_INDEX, 3'h2}, 2'h2, 1'b0, i[0], i[2],
				{i[2], 3'h7, i[0], 2'(i), 1'b0, 8'h80}, 16'h0, 16'h0);
		for (int i = 0; i < 4; i++)
			run_op({eau_pkg::MODE_INDEX, 3'h4}, 2'h1, 1'b0, 1'b0, 1'b1,
				{1'b1, 3'h2, 1'b1, 2'h1, 1'b1, 2'h0, 2'(i), 4'h0}, 16'h8001, 16'h7FFE);
		for (int i = 0; i < 8; i++)
			run_op({eau_pkg::MODE_SPEC, 3'(i)}, 2'h1, 1'b0, 1'b0, 1'b0, 16'hFF10, 16'h0, 16'h0);
		run_op({eau_pkg::MODE_SPEC, eau_pkg::SUB_IMM}, 2'h1, 1'b1, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0);
		for (int i = 0; i < 5; i++)
			impl_chk(i, i[0]);
		repeat (300) begin
			ea = 6'($urandom());
			run_op(ea, 2'($urandom_range(2)), 1'($urandom()) & (ea[5:3] != eau_pkg::MODE_SPEC),
				1'($urandom()), 1'($urandom()), 16'($urandom()), 16'($urandom()),
				16'($urandom()));
			if ($urandom_range(7) == 0)
				load_reg(5'($urandom_range(16)), $urandom());
			if ($urandom_range(7) == 0)
				impl_chk(int'($urandom_range(4)), 1'($urandom()));
		end
		print_verdict();
	end
endmodule // tb_top
